// file: wwdt_pkg.sv
// Purpose: shared constants and types of the windowed watchdog
// Assumes: one core clock, byte-wide register port
// Notes: offsets are register indices on the local port

package wwdt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] OFS_CTL0 = 3'h0;
  localparam logic [2:0] OFS_CTL1 = 3'h1;
  localparam logic [2:0] OFS_PSL = 3'h2;
  localparam logic [2:0] OFS_PSH = 3'h3;
  localparam logic [2:0] OFS_STAT = 3'h4;

  // ****************************************
  // reset values and special codes
  // ****************************************
  localparam logic [4:0] PER_RST = 5'h0B;
  localparam logic [4:0] PER_FREE = 5'h1F;
  localparam logic [4:0] PER_MAX = 5'h12;
  localparam logic [2:0] CS_RST = 3'h0;
  localparam logic [2:0] CS_FREE = 3'h7;
  localparam logic [2:0] WIN_OPEN = 3'h7;
  localparam logic [4:0] PER_BASE_EXP = 5'h05;
  localparam logic [4:0] WIN_STEP_EXP = 5'h02;
  localparam int MF_DIV_DEF = 16;

  // ****************************************
  // counter layout
  // ****************************************
  localparam int PS_W = 18;
  localparam int TOT_W = 23;

  // ****************************************
  // modes and clock sources
  // ****************************************
  typedef enum logic [1:0] {
    WWDT_OFF = 2'b00,
    WWDT_SW = 2'b01,
    WWDT_NOSLP = 2'b10,
    WWDT_ON = 2'b11
  } wwdt_mode_e;

  typedef enum logic [2:0] {
    WWDT_CS_LF = 3'b000,
    WWDT_CS_MF = 3'b001,
    WWDT_CS_SO = 3'b010
  } wwdt_csel_e;

  // configuration word fields, fixed while running
  typedef struct packed {
    wwdt_mode_e watchdog_mode_cfg;
    logic [4:0] period_cfg;
    logic [2:0] clock_select_cfg;
    logic [2:0] window_size_cfg;
  } wwdt_cfg_s;

endpackage : wwdt_pkg

// file: wwdt_tick_sel.sv
// Purpose: pick the watchdog time base and emit one tick per period
// Assumes: oscillator ticks are one-cycle pulses on the core clock
// Notes: reserved selections give no tick at all

`timescale 1ns/1ps

module wwdt_tick_sel
  import wwdt_pkg::*;
#(
  parameter int MF_DIV = MF_DIV_DEF
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] sel_i,
  // oscillator ticks
  input wire logic lf_tick_i,
  input wire logic mf_tick_i,
  input wire logic so_tick_i,
  // selected tick
  output logic tick_o
);

  localparam int DW = $clog2(MF_DIV);

  // ****************************************
  // parameter check
  // ****************************************
  if (MF_DIV < 2 || (1 << DW) != MF_DIV) begin : g_chk
    $error("MF_DIV must be a power of two of at least 2");
  end

  logic [DW-1:0] div_r;
  logic mf_div_tick;

  // mid oscillator prescale, wraps on its own
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else if (ce_i && mf_tick_i) begin
      div_r <= div_r + 1'b1;
    end
  end

  assign mf_div_tick = mf_tick_i && (div_r == '1);

  // source mux, registered to keep the counter path short
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      unique case (sel_i)
        WWDT_CS_LF: begin
          tick_o <= lf_tick_i;
        end
        WWDT_CS_MF: begin
          tick_o <= mf_div_tick;
        end
        WWDT_CS_SO: begin
          tick_o <= so_tick_i;
        end
        default: begin
          tick_o <= 1'b0; // reserved codes stall
        end
      endcase
    end
  end

endmodule : wwdt_tick_sel

// file: wwdt_top.sv
// Purpose: windowed watchdog with period, window and sleep handling
// Assumes: all inputs synchronous to CORE_CLK_I; config stable
// Notes: counter is 18-bit prescaler plus 5-bit counter

`timescale 1ns/1ps

module wwdt_top
  import wwdt_pkg::*;
(
  // clock, reset, enable
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // register port
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // configuration word
  input wire wwdt_cfg_s CFG_I,
  // time base ticks
  input wire logic LF_OSC_TICK_I,
  input wire logic MF_OSC_TICK_I,
  input wire logic SEC_OSC_TICK_I,
  // core events
  input wire logic SLEEP_I,
  input wire logic WATCHDOG_CLEAR_INSTR_I,
  input wire logic OSC_STARTUP_RUN_I,
  input wire logic OSC_FAIL_I,
  input wire logic FLAG_CLR_I,
  input wire logic VIOLATION_FLAG_SET_I,
  // watchdog results
  output logic WDT_RESET_O,
  output logic WDT_WAKE_O,
  output logic TIMEOUT_FLAG_O,
  output logic POWERDOWN_FLAG_O,
  output logic WATCHDOG_RESET_CAUSE_O,
  output logic WINDOW_VIOLATION_FLAG_N_O
);

  // ****************************************
  // helpers
  // ****************************************
  // reserved period codes fold onto the minimum
  function automatic logic [4:0] eff_ps(input logic [4:0] ps);
    eff_ps = (ps > PER_MAX) ? 5'h00 : ps;
  endfunction : eff_ps

  // last count before time-out: 2^(5+n) - 1
  function automatic logic [TOT_W-1:0] per_last(input logic [4:0] ps);
    per_last = ~({TOT_W{1'b1}} << (PER_BASE_EXP + eff_ps(ps)));
  endfunction : per_last

  // first count of the open window, eighths of the period
  function automatic logic [TOT_W-1:0] win_thr(input logic [4:0] ps, input logic [2:0] w);
    logic [TOT_W-1:0] k;
    k = {20'h00000, 3'h7 - w};
    win_thr = k << (WIN_STEP_EXP + eff_ps(ps));
  endfunction : win_thr

  // ****************************************
  // state
  // ****************************************
  logic [4:0] timeout_period_select_r;
  logic software_watchdog_on_r;
  logic [2:0] watchdog_clock_select_r;
  logic [2:0] window_sel_r;
  logic cfg_done_r;
  logic [TOT_W-1:0] cnt_r;
  logic armed_r;
  logic sleep_d_r;
  logic [7:0] rdata_nxt;
  logic tick, active, slp_entry, slp_exit, wr_ctl, windowed;
  logic win_open, clr_req, viol, clr_ok, term, hold, tmo;

  // ****************************************
  // time base
  // ****************************************
  // source selection
  // the system divider never reaches this path
  wwdt_tick_sel #(
    .MF_DIV(MF_DIV_DEF)
  ) u_tick (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .sel_i(watchdog_clock_select_r),
    .lf_tick_i(LF_OSC_TICK_I),
    .mf_tick_i(MF_OSC_TICK_I),
    .so_tick_i(SEC_OSC_TICK_I),
    .tick_o(tick)
  );

  // ****************************************
  // decode of mode and events
  // ****************************************
  // mode table
  // software enable only in mode 01
  // modes 11 and 01 keep counting asleep
  always_comb begin
    unique case (CFG_I.watchdog_mode_cfg)
      WWDT_ON: active = 1'b1;
      WWDT_NOSLP: active = ~SLEEP_I;
      WWDT_SW: active = software_watchdog_on_r;
      WWDT_OFF: active = 1'b0;
    endcase
  end

  assign slp_entry = SLEEP_I & ~sleep_d_r;
  assign slp_exit = ~SLEEP_I & sleep_d_r;
  assign wr_ctl = WR_I & ((ADDR_I == OFS_CTL0) | (ADDR_I == OFS_CTL1));
  // code 111 leaves the window fully open
  assign windowed = window_sel_r != WIN_OPEN;
  assign win_open = cnt_r >= win_thr(timeout_period_select_r, window_sel_r);
  assign clr_req = WATCHDOG_CLEAR_INSTR_I & active & ~SLEEP_I;
  // closed window clear is a violation
  assign viol = clr_req & windowed & ~(armed_r & win_open);
  assign clr_ok = clr_req & ~viol;
  assign term = cnt_r == per_last(timeout_period_select_r);

  assign hold = ~active | OSC_STARTUP_RUN_I | slp_entry | slp_exit | OSC_FAIL_I | wr_ctl | clr_ok | viol;
  assign tmo = active & tick & term & ~hold;

  // ****************************************
  // counter
  // ****************************************
  // prescaler and counter as one chain, wrap on time-out
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_r <= '0;
    end else if (CE_I) begin
      if (hold || tmo) begin
        cnt_r <= '0;
      end else if (tick) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // sleep edge history
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sleep_d_r <= 1'b0;
    end else if (CE_I) begin
      sleep_d_r <= SLEEP_I;
    end
  end

  // arming read, set wins over the clear
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      armed_r <= 1'b0;
    end else if (CE_I) begin
      if (RD_I && ADDR_I == OFS_CTL0) begin
        armed_r <= 1'b1;
      end else if (WATCHDOG_CLEAR_INSTR_I || hold) begin
        armed_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // straps are caught on the first enabled edge after release,
  // never by the asynchronous reset itself
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_done_r <= 1'b0;
      timeout_period_select_r <= PER_RST;
      software_watchdog_on_r <= 1'b0;
      watchdog_clock_select_r <= CS_RST;
      window_sel_r <= WIN_OPEN;
    end else if (CE_I) begin
      if (!cfg_done_r) begin
        cfg_done_r <= 1'b1;
        timeout_period_select_r <= (CFG_I.period_cfg == PER_FREE) ? PER_RST : CFG_I.period_cfg;
        watchdog_clock_select_r <= (CFG_I.clock_select_cfg == CS_FREE) ? CS_RST : CFG_I.clock_select_cfg;
        window_sel_r <= CFG_I.window_size_cfg;
      end else if (WR_I && ADDR_I == OFS_CTL0) begin
        software_watchdog_on_r <= WDATA_I[0];
        if (CFG_I.period_cfg == PER_FREE) begin
          timeout_period_select_r <= WDATA_I[5:1];
        end
      end else if (WR_I && ADDR_I == OFS_CTL1) begin
        if (CFG_I.clock_select_cfg == CS_FREE) begin
          watchdog_clock_select_r <= WDATA_I[6:4];
        end
        if (CFG_I.window_size_cfg == WIN_OPEN) begin
          window_sel_r <= WDATA_I[2:0];
        end
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // register bytes: control, prescaler and status
  always_comb begin
    unique case (ADDR_I)
      OFS_CTL0: rdata_nxt = {2'b00, timeout_period_select_r, software_watchdog_on_r};
      OFS_CTL1: rdata_nxt = {1'b0, watchdog_clock_select_r, 1'b0, window_sel_r};
      OFS_PSL: rdata_nxt = cnt_r[7:0];
      OFS_PSH: rdata_nxt = cnt_r[15:8];
      OFS_STAT: rdata_nxt = {1'b0, cnt_r[PS_W+3:PS_W], armed_r, cnt_r[PS_W-1:16]};
      default: rdata_nxt = 8'h00; // unmapped
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (CE_I) begin
      RDATA_O <= RD_I ? rdata_nxt : 8'h00;
    end
  end

  // ****************************************
  // events and flags
  // ****************************************
  // awake time-out or violation resets
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WDT_RESET_O <= 1'b0;
      WDT_WAKE_O <= 1'b0;
    end else if (CE_I) begin
      WDT_RESET_O <= (tmo & ~SLEEP_I) | viol;
      WDT_WAKE_O <= tmo & SLEEP_I;
    end
  end

  // status flags, event wins over clear
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TIMEOUT_FLAG_O <= 1'b0;
      POWERDOWN_FLAG_O <= 1'b0;
      WATCHDOG_RESET_CAUSE_O <= 1'b0;
    end else if (CE_I) begin
      TIMEOUT_FLAG_O <= tmo | (TIMEOUT_FLAG_O & ~FLAG_CLR_I);
      POWERDOWN_FLAG_O <= (tmo & SLEEP_I) | (POWERDOWN_FLAG_O & ~FLAG_CLR_I);
      WATCHDOG_RESET_CAUSE_O <= tmo | viol | (WATCHDOG_RESET_CAUSE_O & ~FLAG_CLR_I);
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WINDOW_VIOLATION_FLAG_N_O <= 1'b1;
    end else if (CE_I) begin
      if (viol) begin
        WINDOW_VIOLATION_FLAG_N_O <= 1'b0;
      end else if (VIOLATION_FLAG_SET_I) begin
        WINDOW_VIOLATION_FLAG_N_O <= 1'b1;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  property p_slp_entry;
    CE_I && SLEEP_I && !sleep_d_r |=> cnt_r == '0;
  endproperty
  a_slp_entry: assert property (p_slp_entry) else $error("count kept on sleep entry");
  property p_slp_exit;
    CE_I && !SLEEP_I && sleep_d_r |=> cnt_r == '0 && !WDT_RESET_O;
  endproperty
  a_slp_exit: assert property (p_slp_exit) else $error("count kept on sleep exit");
  property p_ost_hold;
    CE_I && OSC_STARTUP_RUN_I ##1 CE_I && OSC_STARTUP_RUN_I |=> cnt_r == '0 && !WDT_WAKE_O;
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("count moved under start-up timer");
  property p_sleep_wake;
    CE_I && tmo && SLEEP_I |=> WDT_WAKE_O && !WDT_RESET_O && POWERDOWN_FLAG_O;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep time-out did not wake");
  property p_off_hold;
    CE_I && CFG_I.watchdog_mode_cfg == WWDT_OFF |=> cnt_r == '0;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("count moved while off");
  property p_rsv_min;
    cfg_done_r && timeout_period_select_r > PER_MAX |-> cnt_r <= 23'h00001F;
  endproperty
  a_rsv_min: assert property (p_rsv_min) else $error("reserved period beyond minimum");
  property p_per_ro;
    CE_I && cfg_done_r && WR_I && ADDR_I == OFS_CTL0 && CFG_I.period_cfg != PER_FREE
      |=> $stable(timeout_period_select_r);
  endproperty
  a_per_ro: assert property (p_per_ro) else $error("locked period changed");
  property p_viol;
    CE_I && clr_req && windowed && !(armed_r && win_open) |=> WDT_RESET_O && !WINDOW_VIOLATION_FLAG_N_O;
  endproperty
  a_viol: assert property (p_viol) else $error("window violation missed");
  property p_wr_clr;
    CE_I && wr_ctl |=> cnt_r == '0 && !armed_r;
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("control write did not clear");
  property p_tmo_rst;
    CE_I && active && tick && term && !hold && !SLEEP_I |=> WDT_RESET_O && WATCHDOG_RESET_CAUSE_O && cnt_r == '0;
  endproperty
  a_tmo_rst: assert property (p_tmo_rst) else $error("awake time-out gave no reset");

  c_tmo: cover property (CE_I && tmo && !SLEEP_I);
  c_wake: cover property (CE_I && tmo && SLEEP_I);
  c_viol: cover property (CE_I && viol);
  c_good_clr: cover property (CE_I && clr_ok && windowed);

endmodule : wwdt_top

// file: wwdt_tb.sv
// Purpose: self-checking bench for the windowed watchdog top
// Assumes: config straps change only while reset is held
// Notes: short period codes keep every time-out within a few hundred ticks

`timescale 1ns/1ps

module tb
  import wwdt_pkg::*;
;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0, clr = 1'b0;
  logic oscillator_startup_timer = 1'b0, ofail = 1'b0, fclr = 1'b0, vset = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [2:0] tk = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  wwdt_cfg_s cfg = '0;
  logic wdt_rst, wake, to_f, pd_f, cause_f, viol_n;
  int fails = 0, comparisons = 0, cyc = 0, rst_seen = 0, wake_seen = 0;

  // clock enable tied high: frozen operation is not part of these scenarios
  wwdt_top dut (.CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CFG_I(cfg), .LF_OSC_TICK_I(tk[0]),
    .MF_OSC_TICK_I(tk[1]), .SEC_OSC_TICK_I(tk[2]), .SLEEP_I(sleep), .WATCHDOG_CLEAR_INSTR_I(clr),
    .OSC_STARTUP_RUN_I(oscillator_startup_timer), .OSC_FAIL_I(ofail), .FLAG_CLR_I(fclr), .VIOLATION_FLAG_SET_I(vset),
    .WDT_RESET_O(wdt_rst), .WDT_WAKE_O(wake), .TIMEOUT_FLAG_O(to_f), .POWERDOWN_FLAG_O(pd_f),
    .WATCHDOG_RESET_CAUSE_O(cause_f), .WINDOW_VIOLATION_FLAG_N_O(viol_n));

  // free-running core clock, 8 ns
  initial begin
    forever #4 clk = ~clk;
  end

  // pulse counters count high cycles, so a clean pulse adds exactly one
  always @(posedge clk) begin
    cyc++;
    if (wdt_rst === 1'b1) rst_seen++;
    if (wake === 1'b1) wake_seen++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  function automatic wwdt_cfg_s mk(input wwdt_mode_e m, input logic [4:0] p, input logic [2:0] c,
                                   input logic [2:0] w);
    mk = {m, p, c, w};
  endfunction : mk

  task do_reset(input wwdt_cfg_s c);
    @(posedge clk);
    rst <= 1'b1;
    cfg <= c;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task rd_chk(input logic [2:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e, what);
  endtask : rd_chk

  // ticks spaced so the registered tick stage never merges two pulses
  task tick(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      tk[k] <= 1'b1;
      @(posedge clk);
      tk[k] <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask : tick

  // 0 clear instruction, 1 flag clear, 2 violation set, 3 oscillator fail
  task pulse(input int k);
    @(posedge clk);
    case (k)
      0: clr <= 1'b1;
      1: fclr <= 1'b1;
      2: vset <= 1'b1;
      default: ofail <= 1'b1;
    endcase
    @(posedge clk);
    {clr, fclr, vset, ofail} <= 4'h0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task ticks_until(input int lim, output int n);
    int base;
    base = rst_seen + wake_seen;
    n = 0;
    while (n < lim && rst_seen + wake_seen == base) begin
      tick(0, 1);
      n++;
    end
  endtask : ticks_until

  // ****************************************
  // scenarios
  // ****************************************
  // reset values and masks
  task s_regs;
    // status first: reading ctl0 arms and would set bit 2
    rd_chk(OFS_STAT, 8'h00, "status reset");
    rd_chk(OFS_CTL0, 8'h16, "ctl0 reset");
    rd_chk(OFS_CTL1, 8'h07, "ctl1 reset");
    rd_chk(OFS_PSL, 8'h00, "psl reset");
    rd_chk(OFS_PSH, 8'h00, "psh reset");
    wr_reg(3'h5, 8'hAA);
    rd_chk(3'h5, 8'h00, "unmapped");
    wr_reg(OFS_CTL0, 8'hFF);
    rd_chk(OFS_CTL0, 8'h3F, "ctl0 mask");
    wr_reg(OFS_CTL1, 8'hFF);
    rd_chk(OFS_CTL1, 8'h77, "ctl1 mask");
    wr_reg(OFS_CTL1, 8'h07);
  endtask : s_regs

  task s_periods;
    logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
    int exp [4] = '{32, 64, 32, 32};
    int n, base;
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFS_CTL0, {2'b00, codes[i], 1'b0});
      base = rst_seen;
      ticks_until(200, n);
      chk(n, exp[i], "ticks to time-out");
      chk(rst_seen - base, 1, "reset pulse");
      chk(to_f, 1'b1, "timeout flag");
      chk(cause_f, 1'b1, "cause flag");
      pulse(1);
    end
  endtask : s_periods

  task s_clears;
    wr_reg(OFS_CTL0, 8'h00);
    tick(0, 10);
    rd_chk(OFS_PSL, 8'h0A, "count ten");
    wr_reg(OFS_CTL1, 8'h07);
    rd_chk(OFS_PSL, 8'h00, "write clears");
    tick(0, 5);
    pulse(3);
    rd_chk(OFS_PSL, 8'h00, "osc fail clears");
    @(posedge clk);
    oscillator_startup_timer <= 1'b1;
    tick(0, 3);
    rd_chk(OFS_PSL, 8'h00, "start-up hold");
    @(posedge clk);
    oscillator_startup_timer <= 1'b0;
    tick(0, 2);
    rd_chk(OFS_PSL, 8'h02, "count resumes");
    pulse(0);
    rd_chk(OFS_PSL, 8'h00, "clear instr");
  endtask : s_clears

  task s_sleep;
    int n, rb;
    wr_reg(OFS_CTL0, 8'h00);
    tick(0, 10);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(OFS_PSL, 8'h00, "sleep entry");
    tick(0, 3);
    rd_chk(OFS_PSL, 8'h03, "sleep counting");
    rb = rst_seen;
    ticks_until(100, n);
    chk(n, 29, "sleep time-out");
    chk(rst_seen - rb, 0, "no reset asleep");
    chk(wake_seen, 1, "wake pulse");
    chk({to_f, pd_f, cause_f}, 3'b111, "wake flags");
    tick(0, 4);
    rd_chk(OFS_PSL, 8'h04, "after wake");
    @(posedge clk);
    sleep <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(OFS_PSL, 8'h00, "sleep exit");
    pulse(1);
  endtask : s_sleep

  task s_window;
    int rb;
    wr_reg(OFS_CTL1, 8'h00);
    tick(0, 5);
    rb = rst_seen;
    pulse(0);
    chk(rst_seen - rb, 1, "unarmed clear");
    chk(viol_n, 1'b0, "violation flag");
    pulse(2);
    chk(viol_n, 1'b1, "violation set back");
    wr_reg(OFS_CTL1, 8'h00);
    tick(0, 5);
    rd_chk(OFS_CTL0, 8'h00, "arming read");
    rd_chk(OFS_STAT, 8'h04, "armed state");
    pulse(0);
    chk(rst_seen - rb, 2, "closed window clear");
    wr_reg(OFS_CTL1, 8'h00);
    tick(0, 29);
    rd_chk(OFS_CTL0, 8'h00, "arming read");
    pulse(0);
    chk(rst_seen - rb, 2, "open window clear");
    rd_chk(OFS_PSL, 8'h00, "window clear");
    rd_chk(OFS_STAT, 8'h00, "disarmed");
  endtask : s_window

  task s_modes;
    do_reset(mk(WWDT_NOSLP, 5'h1F, 3'h7, 3'h7));
    tick(0, 4);
    rd_chk(OFS_PSL, 8'h04, "mode 10 awake");
    @(posedge clk);
    sleep <= 1'b1;
    tick(0, 3);
    rd_chk(OFS_PSL, 8'h00, "mode 10 asleep");
    @(posedge clk);
    sleep <= 1'b0;
    do_reset(mk(WWDT_SW, 5'h1F, 3'h7, 3'h7));
    tick(0, 4);
    rd_chk(OFS_PSL, 8'h00, "software off");
    wr_reg(OFS_CTL0, 8'h01);
    tick(0, 4);
    rd_chk(OFS_PSL, 8'h04, "software on");
    do_reset(mk(WWDT_OFF, 5'h1F, 3'h7, 3'h7));
    wr_reg(OFS_CTL0, 8'h01);
    tick(0, 4);
    rd_chk(OFS_PSL, 8'h00, "mode 00 off");
  endtask : s_modes

  task s_ro;
    do_reset(mk(WWDT_ON, 5'h03, 3'h1, 3'h2));
    rd_chk(OFS_CTL0, 8'h06, "ctl0 strap");
    rd_chk(OFS_CTL1, 8'h12, "ctl1 strap");
    wr_reg(OFS_CTL0, 8'hFF);
    wr_reg(OFS_CTL1, 8'hFF);
    rd_chk(OFS_CTL0, 8'h07, "ctl0 read-only");
    rd_chk(OFS_CTL1, 8'h12, "ctl1 read-only");
    tick(1, 16);
    rd_chk(OFS_PSL, 8'h01, "mid over 16");
    do_reset(mk(WWDT_ON, 5'h03, 3'h2, 3'h7));
    tick(2, 1);
    tick(0, 2);
    rd_chk(OFS_PSL, 8'h01, "secondary only");
  endtask : s_ro

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset(mk(WWDT_ON, 5'h1F, 3'h7, 3'h7));
    s_regs();
    s_periods();
    s_clears();
    s_sleep();
    s_window();
    s_modes();
    s_ro();
    tally_and_finish();
  end

endmodule : tb
